// File: hdl/hub_port_control.sv
// Downstream port enable, babble cut-off, pin forcing and line readback
// Assumes repeater supplies per-port line states synchronous to i_clock
`timescale 1ns/1ns
`include "hub_port_defines.svh"

// What this block does
// - Set enable bit opens port both ways
// - Enabled port repeats upstream unless babbling or suspended
// - No full-speed downstream traffic to low-speed port
// - Enable write waits for packet end
// - Suspended hub raises interrupt on connect change
// - Enable register: bits 0-6 ports, bit 7 reserved
// - Device and bus reset clear enables
// - Non-idle traffic at EOF2 disables port
// - Upstream still connected at EOF2 disables port
// - Two-bit line force code per port 1-4
// - Device reset clears line force register
// - Forced states use speed-matched edge rate
// - Two force-low registers, one bit per pin
// - Force-low unshaped and kept during suspend
// - Data bit shows differential state only
// - Data bit holds value across SE0
// - Resets clear SE0 status and data
// - SE0 status bits 0-6, bit 7 zero
module hub_port_control (
   input wire logic i_clock,
   input wire logic i_rst_b,
   input wire logic i_usb_bus_reset,
   input wire logic [3:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   input wire logic i_packet_active,
   input wire logic i_eof2,
   input wire logic i_upstream_open,
   input wire logic i_upstream_full_speed,
   input wire logic [6:0] i_port_suspended,
   input wire logic [6:0] i_port_non_idle,
   input wire logic [6:0] i_port_dp,
   input wire logic [6:0] i_port_dm,
   input wire logic i_connect_change,
   output logic [6:0] o_port_enabled,
   output logic [6:0] o_down_repeat,
   output logic [6:0] o_up_repeat,
   output logic [6:0] o_drive_oe,
   output logic [6:0] o_drive_dp,
   output logic [6:0] o_drive_dm,
   output logic [6:0] o_drive_slow_edge,
   output logic [6:0] o_dp_force_low,
   output logic [6:0] o_dm_force_low,
   output logic o_hub_irq
);
   logic [7:0] port_enable_mask;
   logic [7:0] pending_enable;
   logic pending_valid;
   logic [7:0] port_line_force_control;
   logic [7:0] pin_force_low_ports_1_4;
   logic [7:0] pin_force_low_ports_5_7;
   logic [7:0] port_speed;
   logic [7:0] hub_ctrl;
   logic [6:0] se0_status;
   logic [6:0] line_data;
   logic [6:0] babble;
   logic [6:0] next_enable;
   logic [13:0] force_low_bits;
   logic [7:0] wr_byte;
   logic bus_go;
   hub_port_pkg::bus_state_e bus_state;

   // Two wait cycles before acking keep read data from a settled register
   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         bus_state <= hub_port_pkg::BUS_IDLE;
      end else begin
         unique case (bus_state)
            hub_port_pkg::BUS_IDLE: begin
               if (i_avs_read || i_avs_write) begin
                  bus_state <= hub_port_pkg::BUS_WAIT;
               end
            end
            hub_port_pkg::BUS_WAIT: begin
               bus_state <= hub_port_pkg::BUS_DONE;
            end
            hub_port_pkg::BUS_DONE: begin
               bus_state <= hub_port_pkg::BUS_IDLE;
            end
            default: begin
               bus_state <= hub_port_pkg::BUS_IDLE;
            end
         endcase
      end
   end

   // Waitrequest drops for the single cycle in BUS_DONE
   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         o_avs_waitrequest <= 1'b1;
      end else begin
         o_avs_waitrequest <= !(bus_state == hub_port_pkg::BUS_WAIT);
      end
   end

   assign bus_go = (bus_state == hub_port_pkg::BUS_DONE) && !o_avs_waitrequest;
   assign wr_byte = i_avs_byteenable[0] ? i_avs_writedata[7:0] : 8'h00;

   // Babble: non-idle at EOF2, or upstream path still open at EOF2
   always_comb begin
      babble = '0;
      if (i_eof2) begin
         babble = port_enable_mask[6:0] &
            (i_port_non_idle | {7{i_upstream_open}});
      end
   end

   // Enable writes apply at once when idle, else after the packet ends
   always_comb begin
      next_enable = port_enable_mask[6:0];
      if (pending_valid && !i_packet_active) begin
         next_enable = pending_enable[6:0];
      end
      next_enable = next_enable & ~babble;
   end

   always_ff @(posedge i_clock) begin
      if (!i_rst_b || i_usb_bus_reset) begin
         port_enable_mask <= `RESET_BYTE;
         pending_valid <= 1'b0;
         pending_enable <= `RESET_BYTE;
      end else if (bus_go && i_avs_write && i_avs_byteenable[0] &&
                   i_avs_address == `OFF_ENABLE) begin
         pending_enable <= wr_byte & `PORT_MASK;
         pending_valid <= i_packet_active;
         if (!i_packet_active) begin
            port_enable_mask <= {1'b0, (wr_byte[6:0] & ~babble)};
         end else begin
            port_enable_mask <= {1'b0, next_enable};
         end
      end else begin
         port_enable_mask <= {1'b0, next_enable};
         if (!i_packet_active) begin
            pending_valid <= 1'b0;
         end
      end
   end

   // Plain firmware registers; line force survives bus reset
   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         port_line_force_control <= `RESET_BYTE;
         pin_force_low_ports_1_4 <= `RESET_BYTE;
         pin_force_low_ports_5_7 <= `RESET_BYTE;
         hub_ctrl <= `RESET_BYTE;
      end else if (bus_go && i_avs_write && i_avs_byteenable[0]) begin
         unique case (i_avs_address)
            `OFF_LINE_FORCE: port_line_force_control <= wr_byte;
            `OFF_FLOW_14: pin_force_low_ports_1_4 <= wr_byte;
            `OFF_FLOW_57: pin_force_low_ports_5_7 <= wr_byte &
               `FORCE_57_MASK;
            `OFF_HUB_CTRL: hub_ctrl <= wr_byte & `HUB_CTRL_MASK;
            default: ;
         endcase
      end
   end

   // Speed register is cleared by bus reset as well
   always_ff @(posedge i_clock) begin
      if (!i_rst_b || i_usb_bus_reset) begin
         port_speed <= `RESET_BYTE;
      end else if (bus_go && i_avs_write && i_avs_byteenable[0] &&
                   i_avs_address == `OFF_SPEED) begin
         port_speed <= wr_byte & `PORT_MASK;
      end
   end

   // Line readback: SE0 flag and differential data held through SE0
   always_ff @(posedge i_clock) begin
      if (!i_rst_b || i_usb_bus_reset) begin
         se0_status <= '0;
         line_data <= '0;
      end else begin
         se0_status <= ~i_port_dp & ~i_port_dm;
         // Per-bit hold, so a port in SE0 never follows another port's data
         line_data <= ((i_port_dp ^ i_port_dm) & i_port_dp) |
            (~(i_port_dp ^ i_port_dm) & line_data);
      end
   end

   // Read mux; unmapped offsets read zero
   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         o_avs_readdata <= '0;
      end else begin
         unique case (i_avs_address)
            `OFF_ENABLE: o_avs_readdata <= {24'h000000, port_enable_mask};
            `OFF_LINE_FORCE:
               o_avs_readdata <= {24'h000000, port_line_force_control};
            `OFF_FLOW_14:
               o_avs_readdata <= {24'h000000, pin_force_low_ports_1_4};
            `OFF_FLOW_57:
               o_avs_readdata <= {24'h000000, pin_force_low_ports_5_7};
            `OFF_SE0: o_avs_readdata <= {25'h0000000, se0_status};
            `OFF_DATA: o_avs_readdata <= {25'h0000000, line_data};
            `OFF_SPEED: o_avs_readdata <= {24'h000000, port_speed};
            `OFF_HUB_CTRL: o_avs_readdata <= {24'h000000, hub_ctrl};
            default: o_avs_readdata <= '0;
         endcase
      end
   end

   // Repeater gating per port
   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         o_port_enabled <= '0;
         o_down_repeat <= '0;
         o_up_repeat <= '0;
      end else begin
         o_port_enabled <= port_enable_mask[6:0];
         o_down_repeat <= port_enable_mask[6:0] & ~i_port_suspended &
            ~(port_speed[6:0] & {7{i_upstream_full_speed}});
         o_up_repeat <= port_enable_mask[6:0] & ~i_port_suspended &
            ~babble;
      end
   end

   assign force_low_bits = {pin_force_low_ports_5_7[5:0],
                            pin_force_low_ports_1_4};

   // Pin forcing: code-driven ports 1-4 use the speed edge rate
   genvar g;
   generate
      for (g = 0; g < `NUM_PORTS; g++) begin : g_pin
         logic [1:0] code;
         if (g < `NUM_FORCED_PORTS) begin : g_code
            assign code = port_line_force_control[2*g+1:2*g];
         end else begin : g_nocode
            assign code = 2'b00;
         end
         always_ff @(posedge i_clock) begin
            if (!i_rst_b) begin
               o_drive_oe[g] <= 1'b0;
               o_drive_dp[g] <= 1'b0;
               o_drive_dm[g] <= 1'b0;
               o_drive_slow_edge[g] <= 1'b0;
               o_dp_force_low[g] <= 1'b0;
               o_dm_force_low[g] <= 1'b0;
            end else begin
               o_drive_oe[g] <= (code != hub_port_pkg::LINE_NORMAL);
               o_drive_dp[g] <= (code == hub_port_pkg::LINE_DIFF_ONE);
               o_drive_dm[g] <= (code == hub_port_pkg::LINE_DIFF_ZERO);
               o_drive_slow_edge[g] <= port_speed[g];
               // Unshaped and independent of suspend state
               o_dp_force_low[g] <= force_low_bits[2*g+1];
               o_dm_force_low[g] <= force_low_bits[2*g];
            end
         end
      end
   endgenerate

   // Connect change while suspended raises interrupt only if interrupt enable is set
   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         o_hub_irq <= 1'b0;
      end else begin
         o_hub_irq <= i_connect_change && hub_ctrl[`HUB_CTRL_SUSPEND] &&
            hub_ctrl[`HUB_CTRL_INT_EN];
      end
   end

   property p_babble_clears;
      @(posedge i_clock) disable iff (!i_rst_b)
      (i_eof2 && i_upstream_open && !i_usb_bus_reset) |=>
         (port_enable_mask[6:0] == 7'h00);
   endproperty
   a_babble_clears: assert property (p_babble_clears)
      else $error("enable survived open upstream at EOF2");

   property p_babble_one_port;
      @(posedge i_clock) disable iff (!i_rst_b)
      (i_eof2 && !i_upstream_open && !pending_valid && !bus_go &&
       !i_usb_bus_reset) |=>
         (port_enable_mask[6:0] == ($past(port_enable_mask[6:0]) &
          ~$past(i_port_non_idle)));
   endproperty
   a_babble_one_port: assert property (p_babble_one_port)
      else $error("babble changed wrong enable bits");

   property p_bus_reset;
      @(posedge i_clock) disable iff (!i_rst_b)
      i_usb_bus_reset |=> (port_enable_mask == 8'h00 && se0_status == 7'h00
         && line_data == 7'h00);
   endproperty
   a_bus_reset: assert property (p_bus_reset)
      else $error("bus reset did not clear state");

   property p_reserved_zero;
      @(posedge i_clock) disable iff (!i_rst_b)
      !port_enable_mask[7] && !pin_force_low_ports_5_7[7];
   endproperty
   a_reserved_zero: assert property (p_reserved_zero)
      else $error("reserved bit set");

   property p_no_fs_to_ls;
      @(posedge i_clock) disable iff (!i_rst_b)
      i_upstream_full_speed ##1 i_upstream_full_speed |->
         ((o_down_repeat & $past(port_speed[6:0])) == 7'h00);
   endproperty
   a_no_fs_to_ls: assert property (p_no_fs_to_ls)
      else $error("full speed sent to low speed port");

   property p_hold_se0;
      @(posedge i_clock) disable iff (!i_rst_b || i_usb_bus_reset)
      (i_port_dp[0] == i_port_dm[0]) |=>
         (line_data[0] == $past(line_data[0]));
   endproperty
   a_hold_se0: assert property (p_hold_se0)
      else $error("data bit moved during SE0");

   property p_wait_packet;
      @(posedge i_clock) disable iff (!i_rst_b || i_usb_bus_reset)
      (pending_valid && i_packet_active && !i_eof2) |=>
         (port_enable_mask == $past(port_enable_mask)) || bus_go;
   endproperty
   a_wait_packet: assert property (p_wait_packet)
      else $error("enable applied mid packet");

   property p_irq;
      @(posedge i_clock) disable iff (!i_rst_b)
      (i_connect_change && hub_ctrl[0] && hub_ctrl[1]) |=> o_hub_irq;
   endproperty
   a_irq: assert property (p_irq)
      else $error("suspended connect gave no interrupt");

   property p_ack_two;
      @(posedge i_clock) disable iff (!i_rst_b)
      (bus_state == hub_port_pkg::BUS_IDLE && i_avs_read) |=>
         o_avs_waitrequest ##1 !o_avs_waitrequest;
   endproperty
   a_ack_two: assert property (p_ack_two)
      else $error("bus ack not at second edge");

   c_babble: cover property (@(posedge i_clock) |babble);
   c_pending: cover property (@(posedge i_clock)
      pending_valid ##1 !pending_valid);
   c_force: cover property (@(posedge i_clock) |o_drive_oe);
   c_irq: cover property (@(posedge i_clock) o_hub_irq);
endmodule

// File: hdl/hub_port_defines.svh
// Register offsets, field positions and reset values of the port control block
// Assumes one 8-bit register per aligned 32-bit Avalon word
`ifndef HUB_PORT_DEFINES_SVH
`define HUB_PORT_DEFINES_SVH
`define NUM_PORTS 7
`define NUM_FORCED_PORTS 4
`define ADDR_W 4
`define OFF_ENABLE 4'h0
`define OFF_LINE_FORCE 4'h1
`define OFF_FLOW_14 4'h2
`define OFF_FLOW_57 4'h3
`define OFF_SE0 4'h4
`define OFF_DATA 4'h5
`define OFF_SPEED 4'h6
`define OFF_HUB_CTRL 4'h7
`define HUB_CTRL_SUSPEND 0
`define HUB_CTRL_INT_EN 1
`define HUB_CTRL_MASK 8'h03
`define RESET_BYTE 8'h00
`define FORCE_57_MASK 8'h3F
`define PORT_MASK 8'h7F
`endif

// File: hdl/hub_port_pkg.sv
// Types shared by the downstream port control block
// Assumes hub_port_defines.svh supplies the numeric constants
package hub_port_pkg;
   typedef enum logic [1:0] {
      LINE_NORMAL = 2'b00,
      LINE_DIFF_ONE = 2'b01,
      LINE_DIFF_ZERO = 2'b10,
      LINE_SE0 = 2'b11
   } line_force_e;
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,
      BUS_WAIT = 2'b01,
      BUS_DONE = 2'b10
   } bus_state_e;
endpackage

// File: verification/usb_dev_model.sv
// Downstream full/low-speed devices seen at the hub's port pins
// Assumes pull-downs on every line, so SE0 or a forced pin reads low
`timescale 1ns/1ns
module usb_dev_model (
   input wire logic [6:0] i_low_speed,
   input wire logic [13:0] i_line_state,
   input wire logic [6:0] i_babble,
   input wire logic [6:0] i_dp_force_low,
   input wire logic [6:0] i_dm_force_low,
   output logic [6:0] o_dp,
   output logic [6:0] o_dm,
   output logic [6:0] o_non_idle
);
   // Two bits a port: 0 J, 1 K, 2 or 3 SE0; J follows the pull-up side
   always_comb begin
      for (int i = 0; i < 7; i++) begin
         o_dp[i] = !i_line_state[2*i+1] & (i_line_state[2*i] ^ !i_low_speed[i])
            & !i_dp_force_low[i];
         o_dm[i] = !i_line_state[2*i+1] & (i_line_state[2*i] ^ i_low_speed[i])
            & !i_dm_force_low[i];
         o_non_idle[i] = i_babble[i] | (i_line_state[2*i+:2] != 2'b00);
      end
   end
endmodule

// File: verification/tb.sv
// Self-checking bench: register model against the port control block
// Assumes usb_dev_model drives the port lines from bench commands
`timescale 1ns/1ns
`include "hub_port_defines.svh"
module tb;
   logic i_clock, i_rst_b, bus_rst, rd, wr, pkt, eof2, up_open, ufs, cc;
   logic [3:0] addr;
   logic [31:0] wdata, rdata, rq, r;
   logic wait_req, irq;
   logic [6:0] susp, lo_spd, babble, dp, dm, non_idle, en_o, dn_rep, up_rep;
   logic [6:0] d_oe, d_dp, d_dm, slow, fl_dp, fl_dm, e_dp, e_dm;
   logic [13:0] lines;
   logic [7:0] m_en, m_lf, m_f14, m_f57, m_spd, m_ctrl, m_data, src, old;
   logic [31:0] seed = 32'h0000A8E2;
   int n_mismatch = 0;
   int n_checks = 0;
   int p, c, hits;

   hub_port_control i_hub_port_control (.i_clock(i_clock), .i_rst_b(i_rst_b),
      .i_usb_bus_reset(bus_rst), .i_avs_address(addr), .i_avs_read(rd),
      .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(4'hF),
      .o_avs_readdata(rdata), .o_avs_waitrequest(wait_req),
      .i_packet_active(pkt), .i_eof2(eof2), .i_upstream_open(up_open),
      .i_upstream_full_speed(ufs), .i_port_suspended(susp),
      .i_port_non_idle(non_idle), .i_port_dp(dp), .i_port_dm(dm),
      .i_connect_change(cc), .o_port_enabled(en_o), .o_down_repeat(dn_rep),
      .o_up_repeat(up_rep), .o_drive_oe(d_oe), .o_drive_dp(d_dp),
      .o_drive_dm(d_dm), .o_drive_slow_edge(slow), .o_dp_force_low(fl_dp),
      .o_dm_force_low(fl_dm), .o_hub_irq(irq));

   usb_dev_model i_usb_dev_model (.i_low_speed(lo_spd), .i_line_state(lines),
      .i_babble(babble), .i_dp_force_low(fl_dp), .i_dm_force_low(fl_dm),
      .o_dp(dp), .o_dm(dm), .o_non_idle(non_idle));

   // 20 MHz clock
   initial begin
      i_clock = 1'b0;
      forever #25 i_clock = ~i_clock;
   end

   // Line data model: holds across SE0, cleared by either reset
   always @(posedge i_clock) begin
      for (int i = 0; i < 7; i++) begin
         if (!i_rst_b || bus_rst)
            m_data[i] <= 1'b0;
         else if (dp[i] !== dm[i])
            m_data[i] <= dp[i];
      end
   end

   function logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   function logic [7:0] exp_reg(input logic [3:0] a);
      case (a)
         4'h0: exp_reg = m_en;
         4'h1: exp_reg = m_lf;
         4'h2: exp_reg = m_f14;
         4'h3: exp_reg = m_f57;
         4'h4: exp_reg = {1'b0, ~dp & ~dm};
         4'h5: exp_reg = {1'b0, m_data[6:0]};
         4'h6: exp_reg = m_spd;
         4'h7: exp_reg = m_ctrl;
         default: exp_reg = 8'h00;
      endcase
   endfunction

   task finish_test;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask

   // Request held until waitrequest is sampled low, then released
   task bus(input logic w, input logic [3:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge i_clock);
      addr <= a;
      wr <= w;
      rd <= !w;
      wdata <= {24'h000000, d};
      do begin
         @(posedge i_clock);
         n++;
      end while (wait_req !== 1'b0 && n < 40);
      rq = rdata;
      chk("bus answer", 32'h00000001, n < 40);
      rd <= 1'b0;
      wr <= 1'b0;
   endtask

   task wreg(input logic [3:0] a, input logic [7:0] d);
      bus(1'b1, a, d);
      case (a)
         4'h0: m_en = d & 8'h7F;
         4'h1: m_lf = d;
         4'h2: m_f14 = d;
         4'h3: m_f57 = d & 8'h3F;
         4'h6: m_spd = d & 8'h7F;
         4'h7: m_ctrl = d & 8'h03;
         default: ;
      endcase
   endtask

   task rd_chk(input logic [3:0] a);
      bus(1'b0, a, 8'h00);
      chk($sformatf("reg %0d", a), {24'h000000, exp_reg(a)}, rq);
   endtask

   task chk_out;
      chk("enabled", m_en[6:0], en_o);
      chk("down", m_en[6:0] & ~susp & ~(m_spd[6:0] & {7{ufs}}),
         dn_rep);
      chk("up", m_en[6:0] & ~susp, up_rep);
      chk("slow edge", m_spd[6:0], slow);
   endtask

   task pulse_eof2;
      @(posedge i_clock);
      eof2 <= 1'b1;
      @(posedge i_clock);
      eof2 <= 1'b0;
      babble <= 7'h00;
      repeat (3) @(posedge i_clock);
   endtask

   // Hang guard, far above the expected run of under a thousand cycles
   initial begin
      repeat (20000) @(posedge i_clock);
      n_mismatch++;
      finish_test;
   end

   initial begin
      {i_rst_b, bus_rst, rd, wr, pkt, eof2, up_open, ufs, cc} = '0;
      {addr, wdata, susp, lo_spd, babble, lines} = '0;
      {m_en, m_lf, m_f14, m_f57, m_spd, m_ctrl} = '0;
      repeat (20) @(posedge i_clock);
      i_rst_b <= 1'b1;
      for (int a = 0; a < 8; a++)
         rd_chk(4'(a));
      // Unmapped offsets keep nothing
      wreg(4'h9, 8'hFF);
      rd_chk(4'h9);
      rd_chk(4'hF);
      // Random enables, speeds and traffic conditions
      for (int k = 0; k < 6; k++) begin
         r = xs();
         susp <= r[6:0];
         ufs <= r[7];
         lo_spd <= r[22:16];
         wreg(4'h6, {1'b0, r[22:16]});
         wreg(4'h0, {1'b0, r[30:24]});
         repeat (3) @(posedge i_clock);
         chk_out();
         rd_chk(4'h0);
      end
      // Enable written mid-packet waits for the packet end
      pkt <= 1'b1;
      old = m_en;
      wreg(4'h0, 8'h7F);
      m_en = old;
      repeat (4) @(posedge i_clock);
      chk_out();
      pkt <= 1'b0;
      m_en = 8'h7F;
      repeat (3) @(posedge i_clock);
      chk_out();
      // Babble on one port at EOF2 removes that port alone
      r = xs();
      p = r % 7;
      babble <= 7'(1 << p);
      pulse_eof2();
      m_en[p] = 1'b0;
      chk_out();
      pulse_eof2();
      chk_out();
      // Upstream still open at EOF2 cuts every enabled port
      up_open <= 1'b1;
      pulse_eof2();
      up_open <= 1'b0;
      m_en = 8'h00;
      chk_out();
      // Every force code on every forcing port, enables already clear
      for (p = 0; p < 4; p++) begin
         for (c = 0; c < 4; c++) begin
            wreg(4'h1, 8'(c << (2 * p)));
            repeat (3) @(posedge i_clock);
            chk("drive oe", 7'(c != 0) << p, d_oe);
            chk("drive dp", 7'(c == 1) << p, d_dp);
            chk("drive dm", 7'(c == 2) << p, d_dm);
         end
      end
      rd_chk(4'h1);
      wreg(4'h1, 8'h00);
      // Force-low pins against random line states
      for (int k = 0; k < 6; k++) begin
         r = xs();
         lines <= r[29:16];
         lo_spd <= r[30:24];
         wreg(4'h2, r[7:0]);
         wreg(4'h3, r[15:8]);
         repeat (3) @(posedge i_clock);
         for (int i = 0; i < 7; i++) begin
            src = (i < 4) ? m_f14 >> (2 * i) : m_f57 >> (2 * (i - 4));
            e_dp[i] = src[1];
            e_dm[i] = src[0];
         end
         chk("dp force low", e_dp, fl_dp);
         chk("dm force low", e_dm, fl_dm);
         rd_chk(4'h2);
         rd_chk(4'h3);
         rd_chk(4'h4);
         rd_chk(4'h5);
      end
      wreg(4'h2, 8'h00);
      wreg(4'h3, 8'h00);
      // Connect change while suspended: irq only with interrupt enabled
      for (c = 1; c < 4; c++) begin
         wreg(4'h7, 8'(c));
         @(posedge i_clock);
         cc <= 1'b1;
         @(posedge i_clock);
         cc <= 1'b0;
         hits = 0;
         repeat (3) begin
            @(posedge i_clock);
            hits += (irq === 1'b1);
         end
         chk("irq pulses", c == 3, hits);
      end
      wreg(4'h7, 8'h00);
      // Bus reset with lines falling to SE0: data stays cleared
      lines <= 14'h0000;
      lo_spd <= 7'h00;
      wreg(4'h6, 8'h55);
      wreg(4'h0, 8'h7F);
      repeat (3) @(posedge i_clock);
      lines <= 14'h2AAA;
      bus_rst <= 1'b1;
      repeat (4) @(posedge i_clock);
      bus_rst <= 1'b0;
      m_en = 8'h00;
      m_spd = 8'h00;
      repeat (3) @(posedge i_clock);
      chk_out();
      rd_chk(4'h0);
      rd_chk(4'h4);
      rd_chk(4'h5);
      rd_chk(4'h6);
      finish_test;
   end
endmodule
